//--- rtl/drive_param_mem.sv
// Parameter word store with a registered read port.
// Assumes the owner decides visibility and supplies override words for special indices.
`timescale 1ns/1ps
module drive_param_mem (
	input  wire logic                         ref_clk,      // System clock
	input  wire logic                         sys_rst,      // Async reset, high
	input  wire logic                         wr_en,        // Store word
	input  wire logic [drive_pkg::ADDR_W-1:0] wr_addr,      // Store index
	input  wire logic [drive_pkg::DATA_W-1:0] wr_data,      // Store word value
	input  wire logic                         rd_en,        // Load read register
	input  wire logic [drive_pkg::ADDR_W-1:0] rd_addr,      // Read index
	input  wire logic                         rd_override,  // Use override word
	input  wire logic [drive_pkg::DATA_W-1:0] rd_ovr_data,  // Override word
	output logic      [drive_pkg::DATA_W-1:0] rd_data       // Registered read word
);
	import drive_pkg::*;

	logic [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

	// Plain storage, no reset: untouched words read undefined until written
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			words[wr_addr] <= wr_data;
		end
	end

	// Read word held until the next read
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= ZERO_WORD;
		end else if (rd_en) begin
			rd_data <= rd_override ? rd_ovr_data : words[rd_addr];
		end
	end
endmodule : drive_param_mem

//--- rtl/drive_pkg.sv
// Shared constants for the drive run, ramp and parameter access logic.
// Assumes a single 250 MHz clock and a parameter index space of 8 bits.
package drive_pkg;
	// Parameter bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int SP_W   = 12;

	// Parameter indices (basic/extended/advanced numbers map straight onto the address)
	localparam logic [ADDR_W-1:0] PAR_FMAX     = 8'h01;
	localparam logic [ADDR_W-1:0] PAR_ACCEL    = 8'h03;
	localparam logic [ADDR_W-1:0] PAR_DECEL    = 8'h04;
	localparam logic [ADDR_W-1:0] PAR_ACCESS   = 8'h0E;
	localparam logic [ADDR_W-1:0] PAR_QSTOP    = 8'h18;
	localparam logic [ADDR_W-1:0] PAR_PASSWORD = 8'h25;

	// Group boundaries, all inclusive
	localparam logic [ADDR_W-1:0] BASIC_FIRST  = 8'h01;
	localparam logic [ADDR_W-1:0] BASIC_LAST   = 8'h0E;
	localparam logic [ADDR_W-1:0] EXT_LAST     = 8'h3B;
	localparam logic [ADDR_W-1:0] ADV_LAST     = 8'h44;
	localparam logic [ADDR_W-1:0] MON_FIRST    = 8'h81;
	localparam logic [ADDR_W-1:0] MON_LAST     = 8'h9E;
	localparam logic [ADDR_W-1:0] MONADV_LAST  = 8'hB2;

	// Monitor values, read only
	localparam logic [ADDR_W-1:0] MON_OUT_FREQ = 8'h81;
	localparam logic [ADDR_W-1:0] MON_TARGET   = 8'h82;
	localparam logic [ADDR_W-1:0] MON_STATUS   = 8'h83;
	localparam int STAT_READY  = 0;
	localparam int STAT_RUN    = 1;
	localparam int STAT_REV    = 2;
	localparam int STAT_QSTOP  = 3;
	localparam int STAT_LVL_LO = 4;
	localparam int STAT_LVL_HI = 5;

	// Reset values; frequency in 0.1 Hz, times in 0.1 s
	localparam logic [DATA_W-1:0] FMAX_DEF     = 16'h01F4;
	localparam logic [DATA_W-1:0] RAMP_DEF     = 16'h0032;
	localparam logic [DATA_W-1:0] QSTOP_DEF    = 16'h0014;
	localparam logic [DATA_W-1:0] PASSWORD_DEF = 16'h0065;
	localparam logic [DATA_W-1:0] ADV_OFFSET   = 16'h0064;
	localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;
	localparam logic [SP_W-1:0]   SP_FULL      = 12'hFFF;

	// Ramp time base
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_NS        = 100000;
	localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIME_UNIT_NS   = 100000000;
	localparam logic [31:0] TICKS_PER_UNIT = 32'(TIME_UNIT_NS / TICK_NS);

	typedef enum logic [1:0] {LVL_BASIC, LVL_EXT, LVL_ADV} access_level_e;
	typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_QSTOP} run_state_e;
endpackage : drive_pkg

//--- rtl/drive_ramp.sv
// Output frequency ramp: one 0.1 Hz step at most per time base tick.
// Assumes a tick pulse every 0.1 ms and times in 0.1 s units.
`timescale 1ns/1ps
module drive_ramp (
	input  wire logic                         ref_clk,    // System clock
	input  wire logic                         sys_rst,    // Async reset, high
	input  wire logic                         tick,       // Time base pulse
	input  wire logic                         coast,      // Force zero at once
	input  wire logic [drive_pkg::DATA_W-1:0] target,     // Wanted frequency
	input  wire logic [drive_pkg::DATA_W-1:0] fmax,       // Full sweep span
	input  wire logic [drive_pkg::DATA_W-1:0] up_time,    // Time for 0 to fmax
	input  wire logic [drive_pkg::DATA_W-1:0] down_time,  // Time for fmax to 0
	output logic      [drive_pkg::DATA_W-1:0] freq        // Present frequency
);
	import drive_pkg::*;

	logic [31:0] acc_r;
	logic [31:0] limit;
	logic [31:0] acc_sum;
	logic [DATA_W-1:0] sel_time;

	// Slope is fmax per programmed time in either direction
	always_comb begin
		sel_time = (freq < target) ? up_time : down_time;
		if (sel_time == ZERO_WORD) begin
			sel_time = 16'h0001;
		end
		limit   = 32'(sel_time) * TICKS_PER_UNIT;
		acc_sum = acc_r + 32'(fmax);
	end

	// Fractional accumulator; slope saturates at one step per tick for very short times
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_r <= 32'h00000000;
			freq  <= ZERO_WORD;
		end else if (coast) begin
			acc_r <= 32'h00000000;
			freq  <= ZERO_WORD;
		end else if (tick) begin
			if (freq == target) begin
				acc_r <= 32'h00000000;
			end else if (acc_sum >= limit) begin
				acc_r <= acc_sum - limit;
				freq  <= (freq < target) ? freq + 16'h0001 : freq - 16'h0001;
			end else begin
				acc_r <= acc_sum;
			end
		end
	end
endmodule : drive_ramp

//--- rtl/drive_run_ramp_control.sv
// Run enable, frequency ramp and tiered parameter access of the drive.
// Assumes enable inputs and setpoint code already synchronous to ref_clk.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module drive_run_ramp_control #(
	parameter int TICK_CYCLES_P = drive_pkg::TICK_CYCLES  // Cycles per ramp tick
) (
	input  wire logic                         ref_clk,         // 250 MHz clock
	input  wire logic                         sys_rst,         // Async reset, high
	input  wire logic                         forward_enable,  // Run clockwise
	input  wire logic                         reverse_enable,  // Run counterclockwise
	input  wire logic [drive_pkg::SP_W-1:0]   setpoint,        // Setpoint code
	input  wire logic [drive_pkg::ADDR_W-1:0] par_addr,        // Parameter index
	input  wire logic [drive_pkg::DATA_W-1:0] par_wdata,       // Write word
	input  wire logic                         par_wr,          // Write strobe
	input  wire logic                         par_rd,          // Read strobe
	output logic      [drive_pkg::DATA_W-1:0] par_rdata,       // Read word, next cycle
	output logic                              ready,           // Drive ready
	output logic                              inverter_on,     // Output stage enabled
	output logic                              dir_reverse,     // Counterclockwise field
	output logic      [drive_pkg::DATA_W-1:0] out_freq         // Output freq, 0.1 Hz
);
	import drive_pkg::*;

	// Index visibility for each access level
	function automatic logic param_visible(input logic [ADDR_W-1:0] a,
	                                       input access_level_e lvl);
		logic basic;
		logic ext;
		logic adv;
		basic = (a >= BASIC_FIRST) && (a <= BASIC_LAST);
		ext   = ((a > BASIC_LAST) && (a <= EXT_LAST)) || ((a >= MON_FIRST) && (a <= MON_LAST));
		adv   = ((a > EXT_LAST) && (a <= ADV_LAST)) || ((a > MON_LAST) && (a <= MONADV_LAST));
		unique case (lvl)
			LVL_BASIC: param_visible = basic;
			LVL_EXT:   param_visible = basic || ext;
			LVL_ADV:   param_visible = basic || ext || adv;
			default:   param_visible = 1'b0;
		endcase
	endfunction : param_visible

	// Monitor indices take no writes
	function automatic logic param_is_monitor(input logic [ADDR_W-1:0] a);
		param_is_monitor = (a >= MON_FIRST) && (a <= MONADV_LAST);
	endfunction : param_is_monitor

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES_P - 1);

	run_state_e        run_state_r;
	run_state_e        run_state_nxt;
	access_level_e     level_r;
	access_level_e     level_nxt;
	logic              dir_nxt;
	logic              fwd_prev_r;
	logic              rev_prev_r;
	logic              fwd_rise;
	logic              rev_rise;
	logic              active_en;
	logic [15:0]       tick_cnt_r;
	logic              tick_r;
	logic [DATA_W-1:0] fmax_r;
	logic [DATA_W-1:0] accel_r;
	logic [DATA_W-1:0] decel_r;
	logic [DATA_W-1:0] qstop_r;
	logic [DATA_W-1:0] access_r;
	logic [DATA_W-1:0] password_r;
	logic [DATA_W-1:0] target;
	logic [DATA_W-1:0] ramp_target;
	logic [DATA_W-1:0] ramp_down;
	logic [DATA_W-1:0] ramp_freq;
	logic [27:0]       sp_product;
	logic              wr_ok;
	logic              rd_override;
	logic [DATA_W-1:0] rd_ovr_data;
	logic [DATA_W-1:0] status_word;

	// Linear setpoint scaling, full code gives fmax
	always_comb begin
		sp_product = 28'(setpoint) * 28'(fmax_r);
		target     = 16'(sp_product / 28'(SP_FULL));
	end

	// Edge detect of the enables; a held enable never restarts the drive
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_prev_r <= 1'b0;
			rev_prev_r <= 1'b0;
		end else begin
			fwd_prev_r <= forward_enable;
			rev_prev_r <= reverse_enable;
		end
	end

	assign fwd_rise  = forward_enable & ~fwd_prev_r;
	assign rev_rise  = reverse_enable & ~rev_prev_r;
	assign active_en = dir_reverse ? reverse_enable : forward_enable;

	// Run sequencing
	always_comb begin
		run_state_nxt = run_state_r;
		dir_nxt       = dir_reverse;
		unique case (run_state_r)
			ST_STOP: begin
				// Start only on a fresh edge with the other enable open
				if (fwd_rise && !reverse_enable) begin
					run_state_nxt = ST_RUN;
					dir_nxt       = 1'b0;
				end else if (rev_rise && !forward_enable) begin
					run_state_nxt = ST_RUN;
					dir_nxt       = 1'b1;
				end
			end
			ST_RUN: begin
				if (forward_enable && reverse_enable) begin
					run_state_nxt = ST_QSTOP;
				end else if (!active_en) begin
					run_state_nxt = ST_STOP;
				end
			end
			ST_QSTOP: begin
				if (!forward_enable && !reverse_enable) begin
					run_state_nxt = ST_STOP;
				end else if (ramp_freq == ZERO_WORD) begin
					run_state_nxt = ST_STOP;
				end
			end
		endcase
	end

	// Run state and the pin-facing flags
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_state_r <= ST_STOP;
			dir_reverse <= 1'b0;
			inverter_on <= 1'b0;
		end else begin
			run_state_r <= run_state_nxt;
			dir_reverse <= dir_nxt;
			inverter_on <= (run_state_nxt != ST_STOP);
		end
	end

	// Ready once out of reset; supply sequencing is outside this block
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready <= 1'b0;
		end else begin
			ready <= 1'b1;
		end
	end

	// Ramp time base, one tick per 0.1 ms
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_r <= 16'h0000;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r >= TICK_LAST) begin
			tick_cnt_r <= 16'h0000;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
			tick_r     <= 1'b0;
		end
	end

	// Quick stop aims at zero on its own down time
	always_comb begin
		ramp_target = (run_state_r == ST_RUN) ? target : ZERO_WORD;
		ramp_down   = (run_state_r == ST_QSTOP) ? qstop_r : decel_r;
	end

	// Coasting forces zero in the same edge the stop is taken
	drive_ramp u_ramp (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.tick      (tick_r),
		.coast     (run_state_nxt == ST_STOP),
		.target    (ramp_target),
		.fmax      (fmax_r),
		.up_time   (accel_r),
		.down_time (ramp_down),
		.freq      (ramp_freq)
	);

	assign out_freq = ramp_freq;

	// Writes land only where the present level can see a non-monitor index
	assign wr_ok = par_wr && param_visible(par_addr, level_r) && !param_is_monitor(par_addr);

	// Key parameters held in flops so their reset values are defined
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fmax_r     <= FMAX_DEF;
			accel_r    <= RAMP_DEF;
			decel_r    <= RAMP_DEF;
			qstop_r    <= QSTOP_DEF;
			access_r   <= ZERO_WORD;
			password_r <= PASSWORD_DEF;
		end else if (wr_ok) begin
			unique case (par_addr)
				PAR_FMAX:     fmax_r     <= par_wdata;
				PAR_ACCEL:    accel_r    <= par_wdata;
				PAR_DECEL:    decel_r    <= par_wdata;
				PAR_QSTOP:    qstop_r    <= par_wdata;
				PAR_ACCESS:   access_r   <= par_wdata;
				PAR_PASSWORD: password_r <= par_wdata;
				default: ;
			endcase
		end
	end

	// Access level decided on each access code write
	always_comb begin
		level_nxt = level_r;
		if (wr_ok && (par_addr == PAR_ACCESS)) begin
			if (par_wdata == password_r) begin
				level_nxt = LVL_EXT;
			end else if (par_wdata == password_r + ADV_OFFSET) begin
				level_nxt = LVL_ADV;
			end else begin
				level_nxt = LVL_BASIC;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_r <= LVL_BASIC;
		end else begin
			level_r <= level_nxt;
		end
	end

	// Status word for the monitor group
	always_comb begin
		status_word                           = ZERO_WORD;
		status_word[STAT_READY]               = ready;
		status_word[STAT_RUN]                 = inverter_on;
		status_word[STAT_REV]                 = dir_reverse;
		status_word[STAT_QSTOP]               = (run_state_r == ST_QSTOP);
		status_word[STAT_LVL_HI:STAT_LVL_LO]  = level_r;
	end

	// Read source: hidden reads as zero, key words from flops, MON_OUT_FREQ/MON_TARGET/MON_STATUS from ramp, setpoint scaling and status, other monitor words zero
	always_comb begin
		rd_override = 1'b1;
		rd_ovr_data = ZERO_WORD;
		if (param_visible(par_addr, level_r)) begin
			unique case (par_addr)
				PAR_FMAX:     rd_ovr_data = fmax_r;
				PAR_ACCEL:    rd_ovr_data = accel_r;
				PAR_DECEL:    rd_ovr_data = decel_r;
				PAR_QSTOP:    rd_ovr_data = qstop_r;
				PAR_ACCESS:   rd_ovr_data = access_r;
				PAR_PASSWORD: rd_ovr_data = password_r;
				MON_OUT_FREQ: rd_ovr_data = ramp_freq;
				MON_TARGET:   rd_ovr_data = target;
				MON_STATUS:   rd_ovr_data = status_word;
				default:      rd_override = param_is_monitor(par_addr);
			endcase
		end
	end

	// Remaining parameters kept in the word store
	drive_param_mem u_mem (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.wr_en       (wr_ok),
		.wr_addr     (par_addr),
		.wr_data     (par_wdata),
		.rd_en       (par_rd),
		.rd_addr     (par_addr),
		.rd_override (rd_override),
		.rd_ovr_data (rd_ovr_data),
		.rd_data     (par_rdata)
	);
endmodule : drive_run_ramp_control

//--- sim/drive_run_ramp_control_chk.sv
// Checker for the run, ramp and parameter access block.
// Assumes it is bound onto drive_run_ramp_control with TICK_CYCLES_P of 4 or more.
`timescale 1ns/1ps
module drive_run_ramp_control_chk #(
	parameter int TICK_CYCLES_P = 4  // Cycles per ramp tick
) (
	input wire logic                         ref_clk,         // Clock
	input wire logic                         sys_rst,         // Async reset
	input wire logic                         forward_enable,  // Run clockwise
	input wire logic                         reverse_enable,  // Run counterclockwise
	input wire logic [drive_pkg::SP_W-1:0]   setpoint,        // Setpoint code
	input wire logic [drive_pkg::ADDR_W-1:0] par_addr,        // Parameter index
	input wire logic [drive_pkg::DATA_W-1:0] par_wdata,       // Write word
	input wire logic                         par_wr,          // Write strobe
	input wire logic                         par_rd,          // Read strobe
	input wire logic [drive_pkg::DATA_W-1:0] par_rdata,       // Read word
	input wire logic                         ready,           // Drive ready
	input wire logic                         inverter_on,     // Output stage on
	input wire logic                         dir_reverse,     // Counterclockwise
	input wire logic [drive_pkg::DATA_W-1:0] out_freq         // Output frequency
);
	import drive_pkg::*;
	// Single domain, so clock and reset are stated once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Ready from the first edge after release; stopped means zero frequency
	a_ready_up: assert property (!$past(sys_rst) |-> ready)
		else $error("Ready low after reset");
	a_stop_zero: assert property (!inverter_on |-> out_freq == ZERO_WORD)
		else $error("Frequency nonzero while stopped");
	// Start needs a fresh edge of one enable, the other low
	a_start_fwd: assert property ($rose(forward_enable) && !reverse_enable
		&& !inverter_on |=> inverter_on && !dir_reverse)
		else $error("Forward start missing");
	a_start_rev: assert property ($rose(reverse_enable) && !forward_enable
		&& !inverter_on |=> inverter_on && dir_reverse)
		else $error("Reverse start missing");
	a_stay_stop: assert property (!inverter_on && !$rose(forward_enable)
		&& !$rose(reverse_enable) |=> !inverter_on)
		else $error("Restart without new enable");
	a_dir_hold: assert property (inverter_on && $past(inverter_on) |-> $stable(dir_reverse))
		else $error("Direction changed while running");
	// Both enables dropped: coast at once
	a_coast_now: assert property (inverter_on && !forward_enable && !reverse_enable
		|=> !inverter_on && out_freq == ZERO_WORD)
		else $error("No immediate stop");
	// Gradual ramp: one unit per step, steps at least four cycles apart
	a_step_size: assert property (inverter_on && $past(inverter_on) |->
		out_freq == $past(out_freq) || out_freq == $past(out_freq) + 16'h0001
		|| out_freq + 16'h0001 == $past(out_freq))
		else $error("Frequency jumped");
	a_step_gap: assert property (inverter_on && $changed(out_freq)
		|=> (!inverter_on || $stable(out_freq)) [*3])
		else $error("Steps too close");
	a_qstop_down: assert property (inverter_on && forward_enable && reverse_enable
		##1 inverter_on && forward_enable && reverse_enable
		|=> out_freq <= $past(out_freq))
		else $error("Frequency rose in quick stop");
	// Indices between the advanced and monitor groups read as zero
	a_gap_read: assert property (par_rd && par_addr > ADV_LAST && par_addr < MON_FIRST
		|=> par_rdata == ZERO_WORD)
		else $error("Gap index read nonzero");
	c_start: cover property ($rose(inverter_on));
	c_qstop: cover property (inverter_on && forward_enable && reverse_enable);
	c_coast: cover property ($fell(inverter_on) && !forward_enable && !reverse_enable);
endmodule : drive_run_ramp_control_chk

bind drive_run_ramp_control drive_run_ramp_control_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .forward_enable(forward_enable),
	.reverse_enable(reverse_enable), .setpoint(setpoint), .par_addr(par_addr),
	.par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata),
	.ready(ready), .inverter_on(inverter_on), .dir_reverse(dir_reverse), .out_freq(out_freq)
);

//--- sim/enable_contacts.sv
// Model of the external enable contacts wired to the drive.
// Assumes the bench commands the contacts; each follows one edge later.
`timescale 1ns/1ps
module enable_contacts (
	input  wire logic ref_clk,         // System clock
	input  wire logic sys_rst,         // Power-on state
	input  wire logic close_fwd,       // Close clockwise contact
	input  wire logic close_rev,       // Close counterclockwise contact
	output logic      forward_enable,  // Clockwise run request
	output logic      reverse_enable   // Counterclockwise run request
);
	// Open at power on, so the drive never starts on power-up
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			forward_enable <= 1'b0;
			reverse_enable <= 1'b0;
		end else begin
			forward_enable <= close_fwd;
			reverse_enable <= close_rev;
		end
	end
endmodule : enable_contacts

//--- sim/tb_top.sv
// Self-checking bench for the run, ramp and parameter access block.
// Assumes the enable contact model sits in front of the enable inputs.
`timescale 1ns/1ps
module tb_top;
	import drive_pkg::*;
	logic              ref_clk, sys_rst, close_fwd, close_rev, forward_enable, reverse_enable;
	logic              par_wr, par_rd, ready, inverter_on, dir_reverse;
	logic [SP_W-1:0]   setpoint;
	logic [ADDR_W-1:0] par_addr;
	logic [DATA_W-1:0] par_wdata, par_rdata, out_freq;
	int                error_cnt, n_checks;

	// Free-running 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Short tick so a 0.1 s unit is 1000 ticks of 4 cycles
	drive_run_ramp_control #(.TICK_CYCLES_P(4)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .forward_enable(forward_enable),
		.reverse_enable(reverse_enable), .setpoint(setpoint), .par_addr(par_addr),
		.par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata),
		.ready(ready), .inverter_on(inverter_on), .dir_reverse(dir_reverse),
		.out_freq(out_freq));
	enable_contacts u_contacts (.ref_clk(ref_clk), .sys_rst(sys_rst), .close_fwd(close_fwd),
		.close_rev(close_rev), .forward_enable(forward_enable),
		.reverse_enable(reverse_enable));

	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Range check, since tick phase blurs the exact step count
	task automatic rng(input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
		chk({15'h0000, (out_freq >= lo) && (out_freq <= hi)}, 16'h0001);
	endtask : rng
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wt
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		par_addr  <= a;
		par_wdata <= d;
		par_wr    <= 1'b1;
		@(posedge ref_clk);
		par_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge ref_clk);
		par_addr <= a;
		par_rd   <= 1'b1;
		@(posedge ref_clk);
		par_rd <= 1'b0;
		#1;
		chk(par_rdata, exp);
	endtask : rdchk
	task automatic en(input logic f, input logic r);
		@(posedge ref_clk);
		close_fwd <= f;
		close_rev <= r;
	endtask : en
	task automatic sp(input logic [SP_W-1:0] v);
		@(posedge ref_clk);
		setpoint <= v;
	endtask : sp
	task automatic report_and_stop;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard, about four times the planned run
	initial begin
		#400000;
		error_cnt++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{close_fwd, close_rev, par_wr, par_rd} = 4'h0;
		setpoint = 12'hFFF;
		par_addr = 8'h00;
		par_wdata = 16'h0000;
		error_cnt = 0;
		n_checks = 0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wt(2);
		chk(16'({ready, inverter_on}), 16'h0002);
		chk(out_freq, ZERO_WORD);
		rdchk(PAR_FMAX, FMAX_DEF);
		rdchk(PAR_ACCEL, RAMP_DEF);
		rdchk(PAR_DECEL, RAMP_DEF);
		rdchk(PAR_QSTOP, ZERO_WORD);
		rdchk(MON_STATUS, ZERO_WORD);
		rdchk(8'h50, ZERO_WORD);
		wr(PAR_ACCESS, PASSWORD_DEF);
		rdchk(PAR_QSTOP, QSTOP_DEF);
		rdchk(MON_STATUS, 16'h0011);
		rdchk(8'h3C, ZERO_WORD);
		rdchk(MON_TARGET, FMAX_DEF);
		sp(12'h800);
		rdchk(MON_TARGET, 16'h00FA);
		// Small span and times keep ramps to a few thousand cycles
		wr(PAR_FMAX, 16'h000A);
		wr(PAR_ACCEL, 16'h0001);
		wr(PAR_DECEL, 16'h0002);
		wr(PAR_QSTOP, 16'h0001);
		sp(12'hFFF);
		en(1'b1, 1'b0);
		wt(4);
		chk(16'({inverter_on, dir_reverse}), 16'h0002);
		wt(1996);
		rng(16'h0004, 16'h0005);
		wt(2200);
		chk(out_freq, 16'h000A);
		rdchk(MON_OUT_FREQ, 16'h000A);
		sp(12'h000);
		wt(4000);
		rng(16'h0004, 16'h0006);
		wt(4400);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0003);
		wr(PAR_ACCEL, 16'h0002);
		sp(12'hFFF);
		wt(4000);
		rng(16'h0004, 16'h0006);
		en(1'b0, 1'b0);
		wt(4);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0001);
		en(1'b1, 1'b0);
		wt(4);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0003);
		wt(2400);
		rng(16'h0002, 16'h0004);
		en(1'b1, 1'b1);
		wt(400);
		chk(16'(inverter_on), 16'h0001);
		rdchk(MON_STATUS, 16'h001B);
		wt(1600);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0001);
		en(1'b1, 1'b0);
		wt(50);
		chk(16'(inverter_on), 16'h0000);
		en(1'b0, 1'b1);
		wt(4);
		chk(16'({inverter_on, dir_reverse}), 16'h0003);
		rdchk(MON_STATUS, 16'h0017);
		// Quick stop cut short by dropping both enables
		wt(1000);
		en(1'b1, 1'b1);
		wt(4);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0002);
		en(1'b0, 1'b0);
		wt(4);
		chk(16'({inverter_on, out_freq == ZERO_WORD}), 16'h0001);
		// Changed password, then advanced, withdrawn and stale codes
		wr(PAR_PASSWORD, 16'h00C8);
		wr(PAR_ACCESS, 16'h012C);
		wr(8'h3C, 16'h1234);
		rdchk(8'h3C, 16'h1234);
		rdchk(MON_STATUS, 16'h0025);
		wr(PAR_ACCESS, 16'h0005);
		// Hidden write must not land; read back later at extended level
		wr(PAR_QSTOP, 16'h0007);
		rdchk(PAR_QSTOP, ZERO_WORD);
		rdchk(8'h3C, ZERO_WORD);
		wr(PAR_ACCESS, PASSWORD_DEF);
		rdchk(PAR_QSTOP, ZERO_WORD);
		wr(PAR_ACCESS, 16'h00C8);
		rdchk(PAR_QSTOP, 16'h0001);
		rdchk(PAR_PASSWORD, 16'h00C8);
		// Reset with the drive stopped brings back defaults and basic access only
		sys_rst <= 1'b1;
		wt(3);
		sys_rst <= 1'b0;
		wt(2);
		chk(16'({ready, inverter_on}), 16'h0002);
		rdchk(PAR_QSTOP, ZERO_WORD);
		wr(PAR_ACCESS, PASSWORD_DEF);
		rdchk(PAR_PASSWORD, PASSWORD_DEF);
		rdchk(PAR_QSTOP, QSTOP_DEF);
		report_and_stop();
	end
endmodule : tb_top
